// *** rtl/setc_pkg.sv ***
package setc_pkg;
   // ----------------------------------------
   // widths and queue sizing
   // ----------------------------------------
   localparam int LVL_W = 16;
   localparam int ERRQ_DEPTH = 8;
   localparam int ERRQ_AW = 3;

   // ----------------------------------------
   // error codes, two's complement
   // ----------------------------------------
   localparam logic signed [15:0] ERR_NONE = 16'sh0000;
   localparam logic signed [15:0] ERR_CMD = 16'shff9c;
   localparam logic signed [15:0] ERR_SYNTAX = 16'shff9a;
   localparam logic signed [15:0] ERR_PARAM = 16'shff94;
   localparam logic signed [15:0] ERR_RANGE = 16'shff22;
   localparam logic signed [15:0] ERR_OVF = 16'shfea2;
   localparam logic signed [15:0] ERR_QUERY = 16'shfe70;
   localparam logic signed [15:0] GRP_CMD_LO = 16'shff39;
   localparam logic signed [15:0] GRP_EXE_HI = 16'shff38;
   localparam logic signed [15:0] GRP_EXE_LO = 16'shfed5;
   localparam logic signed [15:0] GRP_DDE_HI = 16'shfed4;
   localparam logic signed [15:0] GRP_DDE_LO = 16'shfe71;
   localparam logic signed [15:0] GRP_QYE_LO = 16'shfe0d;

   // ----------------------------------------
   // status bit positions and reset values
   // ----------------------------------------
   localparam int ESR_CME = 5;
   localparam int ESR_EXE = 4;
   localparam int ESR_DDE = 3;
   localparam int ESR_QYE = 2;
   localparam logic [7:0] ESR_RST = 8'h80;
   localparam int STB_MAV = 4;
   localparam int STB_ESB = 5;
   localparam int STB_MSS = 6;
   localparam logic [7:0] SRE_MASK = 8'hbf;

   // ----------------------------------------
   // serial framing and timing
   // ----------------------------------------
   localparam longint CLK_HZ = 125000000;
   localparam longint BAUD_RATE = 19200;
   localparam int CHAR_BITS = 10;
   localparam longint IDLE_MIN = 5;
   localparam longint SEC_PER_MIN = 60;

   typedef enum logic [2:0] {
      MSG_NO_ERROR, MSG_CMD, MSG_SYNTAX, MSG_PARAM,
      MSG_RANGE, MSG_OVERFLOW, MSG_QUERY, MSG_OTHER
   } setc_msg_t;

   typedef enum logic [3:0] {
      OP_NOP, OP_ERR_Q, OP_CLS, OP_ESR_Q, OP_ESE_WR, OP_SRE_WR,
      OP_INIT, OP_CONT_WR, OP_TRIG, OP_ABORT, OP_RCL, OP_RST,
      OP_CURR, OP_CURR_TRIG, OP_VOLT, OP_VOLT_TRIG
   } setc_op_t;

   typedef enum logic [1:0] {PORT_NONE, PORT_SER, PORT_GPIB} setc_port_t;

   typedef struct packed {
      logic valid;
      logic src;
      setc_op_t op;
      logic [15:0] data;
   } setc_cmd_t;

   typedef struct packed {
      logic [LVL_W-1:0] curr;
      logic [LVL_W-1:0] volt;
   } setc_lvl_t;
endpackage : setc_pkg

// *** rtl/setc_top.sv ***
// Function
// RULE1: errors queue oldest-first, query pops oldest
// RULE2: empty queue query answers code zero
// RULE3: overflow drops excess, last entry minus 350
// RULE4: error code range sets event bit
// RULE5: fixed codes for listed error kinds
// RULE6: trigger ignored unless armed
// RULE7: trigger copies pending levels to active
// RULE8: single mode arm allows one trigger
// RULE9: continuous mode rearms, sets waiting flag
// RULE10: trigger clears waiting flag
// RULE11: abort makes pending equal immediate levels
// RULE12: abort clears flag, continuous rearms
// RULE13: abort at power-on, recall and reset
// RULE14: serial link 19200 8N1, no flow
// RULE15: first port with traffic owns commands
// RULE16: other port waits five idle minutes
// RULE17: summary bit six, unlatched, service needed
// RULE18: summary is OR of enabled status bits
// RULE19: event bit from enabled event bits
// RULE20: message bit follows unread response
// RULE21: event register read clears it
// RULE22: clear-status empties queue and status
// RULE23: zero enable mask never requests service
// RULE24: queue depth parameter, overflow slot reserved
// RULE25: idle timer derived from clock frequency
`timescale 1ns/1ps
module setc_top #(
   parameter longint CLK_HZ = setc_pkg::CLK_HZ,
   parameter int FRAME_CYCLES =
      int'(CLK_HZ / setc_pkg::BAUD_RATE) * setc_pkg::CHAR_BITS,
   parameter longint IDLE_CYCLES =
      setc_pkg::IDLE_MIN * setc_pkg::SEC_PER_MIN * CLK_HZ
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ser_rx,
   input wire logic gpib_dav_n,
   input wire setc_pkg::setc_cmd_t cmd,
   input wire logic err_valid,
   input wire logic signed [15:0] err_code,
   input wire logic obuf_pending,
   output logic err_resp_valid,
   output logic signed [15:0] err_resp_code,
   output setc_pkg::setc_msg_t err_resp_msg,
   output logic [7:0] esr_rd_data,
   output logic [7:0] status_byte,
   output logic srq,
   output logic obuf_flush,
   output logic waiting_for_trigger_flag,
   output logic trig_armed,
   output logic cont_mode,
   output setc_pkg::setc_lvl_t lvl_active,
   output setc_pkg::setc_lvl_t lvl_pending,
   output setc_pkg::setc_port_t active_port
);
   // ----------------------------------------
   // constants and helpers
   // ----------------------------------------
   localparam logic [35:0] IDLE_LIM = 36'(IDLE_CYCLES - 1);
   localparam logic [16:0] FRAME_LIM = 17'(FRAME_CYCLES - 1);
   localparam logic [3:0] Q_LAST = 4'(setc_pkg::ERRQ_DEPTH - 1);

   function automatic setc_pkg::setc_msg_t msg_of(input logic signed [15:0] c);
      if (c == setc_pkg::ERR_NONE) msg_of = setc_pkg::MSG_NO_ERROR;
      else if (c == setc_pkg::ERR_CMD) msg_of = setc_pkg::MSG_CMD;
      else if (c == setc_pkg::ERR_SYNTAX) msg_of = setc_pkg::MSG_SYNTAX;
      else if (c == setc_pkg::ERR_PARAM) msg_of = setc_pkg::MSG_PARAM;
      else if (c == setc_pkg::ERR_RANGE) msg_of = setc_pkg::MSG_RANGE;
      else if (c == setc_pkg::ERR_OVF) msg_of = setc_pkg::MSG_OVERFLOW;
      else if (c == setc_pkg::ERR_QUERY) msg_of = setc_pkg::MSG_QUERY;
      else msg_of = setc_pkg::MSG_OTHER; // see RULE5
   endfunction : msg_of

   function automatic logic [7:0] grp_of(input logic signed [15:0] c);
      grp_of = 8'h00;
      if (c <= setc_pkg::ERR_CMD && c >= setc_pkg::GRP_CMD_LO)
         grp_of[setc_pkg::ESR_CME] = 1'b1; // see RULE4
      if (c <= setc_pkg::GRP_EXE_HI && c >= setc_pkg::GRP_EXE_LO)
         grp_of[setc_pkg::ESR_EXE] = 1'b1;
      if (c <= setc_pkg::GRP_DDE_HI && c >= setc_pkg::GRP_DDE_LO)
         grp_of[setc_pkg::ESR_DDE] = 1'b1;
      if (c <= setc_pkg::ERR_QUERY && c >= setc_pkg::GRP_QYE_LO)
         grp_of[setc_pkg::ESR_QYE] = 1'b1;
   endfunction : grp_of

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic ser_rx_d_r, dav_d_r, pwr_abort_r;
   logic [16:0] ser_hold_r;
   logic [35:0] idle_r;
   setc_pkg::setc_port_t owner_r;
   logic signed [15:0] q_mem [setc_pkg::ERRQ_DEPTH];
   logic [2:0] rd_r, wr_r;
   logic [3:0] cnt_r;
   logic [7:0] esr_r, ese_r, sre_r, stb_r, esr_rd_r;
   logic srq_r, flush_r, resp_v_r, armed_r, wtg_r, cont_r;
   logic signed [15:0] resp_code_r;
   setc_pkg::setc_msg_t resp_msg_r;
   setc_pkg::setc_lvl_t imm_r, pend_r, act_r;

   // ----------------------------------------
   // port ownership
   // ----------------------------------------
   logic tr_ser, tr_gp, acc, own_act;
   setc_pkg::setc_port_t src_port;
   setc_pkg::setc_op_t op;

   // a start edge outside a character frame marks serial traffic
   assign tr_ser = ser_rx_d_r && !ser_rx && ser_hold_r == 17'h0; // see RULE14
   assign tr_gp = dav_d_r && !gpib_dav_n;
   assign src_port = cmd.src ? setc_pkg::PORT_GPIB : setc_pkg::PORT_SER;
   assign acc = cmd.valid && (owner_r == setc_pkg::PORT_NONE
                || owner_r == src_port); // see RULE15
   assign op = acc ? cmd.op : setc_pkg::OP_NOP;
   assign own_act = acc || (owner_r == setc_pkg::PORT_SER && tr_ser)
                    || (owner_r == setc_pkg::PORT_GPIB && tr_gp);

   // edge history and serial frame guard
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ser_rx_d_r <= 1'b1;
         dav_d_r <= 1'b1;
         ser_hold_r <= 17'h0;
      end else begin
         ser_rx_d_r <= ser_rx;
         dav_d_r <= gpib_dav_n;
         if (tr_ser) ser_hold_r <= FRAME_LIM; // see RULE14
         else if (ser_hold_r != 17'h0) ser_hold_r <= ser_hold_r - 17'h1;
      end
   end

   // owner claim and idle release
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         owner_r <= setc_pkg::PORT_NONE;
         idle_r <= 36'h0;
      end else if (owner_r == setc_pkg::PORT_NONE) begin
         idle_r <= 36'h0;
         if (cmd.valid) owner_r <= src_port; // see RULE15
         else if (tr_ser) owner_r <= setc_pkg::PORT_SER;
         else if (tr_gp) owner_r <= setc_pkg::PORT_GPIB;
      end else if (own_act) begin
         idle_r <= 36'h0;
      end else if (idle_r == IDLE_LIM) begin
         owner_r <= setc_pkg::PORT_NONE; // see RULE16
         idle_r <= 36'h0;
      end else begin
         idle_r <= idle_r + 36'h1; // see RULE25
      end
   end

   // ----------------------------------------
   // error queue
   // ----------------------------------------
   logic cls, pop, push_ok, push_ovf, push_en;
   logic [3:0] cnt_after;
   logic signed [15:0] push_code;

   assign cls = op == setc_pkg::OP_CLS;
   assign pop = op == setc_pkg::OP_ERR_Q && cnt_r != 4'h0 && !cls;
   assign cnt_after = cls ? 4'h0 : cnt_r - {3'h0, pop};
   assign push_ok = err_valid && cnt_after < Q_LAST; // see RULE24
   assign push_ovf = err_valid && cnt_after == Q_LAST; // see RULE3
   assign push_en = push_ok || push_ovf;
   assign push_code = push_ovf ? setc_pkg::ERR_OVF : err_code;

   // entry storage, written at slot zero when cleared in the same cycle
   always_ff @(posedge clk_sys) begin
      if (push_en) q_mem[cls ? 3'h0 : wr_r] <= push_code; // see RULE1
   end

   // pointers and fill count
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_r <= 3'h0;
         wr_r <= 3'h0;
         cnt_r <= 4'h0;
      end else if (cls) begin
         rd_r <= 3'h0; // see RULE22
         wr_r <= {2'h0, push_en};
         cnt_r <= {3'h0, push_en};
      end else begin
         if (pop) rd_r <= rd_r + 3'h1; // see RULE1
         if (push_en) wr_r <= wr_r + 3'h1;
         cnt_r <= cnt_after + {3'h0, push_en};
      end
   end

   // error query answer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         resp_v_r <= 1'b0;
         resp_code_r <= setc_pkg::ERR_NONE;
         resp_msg_r <= setc_pkg::MSG_NO_ERROR;
      end else begin
         resp_v_r <= op == setc_pkg::OP_ERR_Q;
         if (op == setc_pkg::OP_ERR_Q) begin
            resp_code_r <= pop ? q_mem[rd_r] : setc_pkg::ERR_NONE; // see RULE2
            resp_msg_r <= pop ? msg_of(q_mem[rd_r]) : setc_pkg::MSG_NO_ERROR;
         end
      end
   end

   // ----------------------------------------
   // event register, enables and status byte
   // ----------------------------------------
   logic [7:0] esr_set, stb_nxt;
   logic esr_rd;

   assign esr_rd = op == setc_pkg::OP_ESR_Q;
   assign esr_set = (err_valid ? grp_of(err_code) : 8'h00)
                    | (push_ovf ? grp_of(setc_pkg::ERR_OVF) : 8'h00);

   // status byte build, summary is unlatched
   always_comb begin
      stb_nxt = 8'h00;
      stb_nxt[setc_pkg::STB_MAV] = obuf_pending && !cls; // see RULE20
      stb_nxt[setc_pkg::STB_ESB] = |(esr_r & ese_r) && !cls; // see RULE19
      stb_nxt[setc_pkg::STB_MSS] = |(stb_nxt & sre_r & setc_pkg::SRE_MASK); // see RULE18
   end

   // event register, set wins over clear
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         esr_r <= setc_pkg::ESR_RST;
         esr_rd_r <= 8'h00;
      end else begin
         esr_r <= ((esr_rd || cls) ? 8'h00 : esr_r) | esr_set; // see RULE21
         if (esr_rd) esr_rd_r <= esr_r;
      end
   end

   // enable masks and status outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ese_r <= 8'h00;
         sre_r <= 8'h00;
         stb_r <= 8'h00;
         srq_r <= 1'b0;
         flush_r <= 1'b0;
      end else begin
         if (op == setc_pkg::OP_ESE_WR) ese_r <= cmd.data[7:0];
         if (op == setc_pkg::OP_SRE_WR) sre_r <= cmd.data[7:0];
         stb_r <= stb_nxt; // see RULE17
         srq_r <= stb_nxt[setc_pkg::STB_MSS]; // see RULE23
         flush_r <= cls; // see RULE22
      end
   end

   // ----------------------------------------
   // trigger subsystem
   // ----------------------------------------
   logic abort_evt, trig_fire;

   assign abort_evt = pwr_abort_r || op == setc_pkg::OP_ABORT
                      || op == setc_pkg::OP_RCL || op == setc_pkg::OP_RST; // see RULE13
   assign trig_fire = op == setc_pkg::OP_TRIG && armed_r && !abort_evt; // see RULE6

   // arm state, continuous mode and waiting flag
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pwr_abort_r <= 1'b1;
         armed_r <= 1'b0;
         wtg_r <= 1'b0;
         cont_r <= 1'b0;
      end else begin
         pwr_abort_r <= 1'b0;
         if (op == setc_pkg::OP_CONT_WR) cont_r <= cmd.data[0]; // see RULE9
         if (abort_evt) begin
            armed_r <= cont_r; // see RULE12
            wtg_r <= cont_r;
         end else if (trig_fire) begin
            armed_r <= cont_r; // see RULE8
            wtg_r <= cont_r; // see RULE10
         end else if (op == setc_pkg::OP_INIT) begin
            armed_r <= 1'b1;
            wtg_r <= 1'b1;
         end
      end
   end

   // immediate, pending and active levels
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         imm_r <= '0;
         pend_r <= '0;
         act_r <= '0;
      end else if (abort_evt) begin
         pend_r <= imm_r; // see RULE11
      end else if (trig_fire) begin
         act_r <= pend_r; // see RULE7
         imm_r <= pend_r;
      end else begin
         if (op == setc_pkg::OP_CURR) begin
            imm_r.curr <= cmd.data;
            act_r.curr <= cmd.data;
         end
         if (op == setc_pkg::OP_VOLT) begin
            imm_r.volt <= cmd.data;
            act_r.volt <= cmd.data;
         end
         if (op == setc_pkg::OP_CURR_TRIG) pend_r.curr <= cmd.data;
         if (op == setc_pkg::OP_VOLT_TRIG) pend_r.volt <= cmd.data;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign err_resp_valid = resp_v_r;
   assign err_resp_code = resp_code_r;
   assign err_resp_msg = resp_msg_r;
   assign esr_rd_data = esr_rd_r;
   assign status_byte = stb_r;
   assign srq = srq_r;
   assign obuf_flush = flush_r;
   assign waiting_for_trigger_flag = wtg_r;
   assign trig_armed = armed_r;
   assign cont_mode = cont_r;
   assign lvl_active = act_r;
   assign lvl_pending = pend_r;
   assign active_port = owner_r;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_empty_zero;
      op == setc_pkg::OP_ERR_Q && cnt_r == 4'h0 |=> err_resp_code == 16'sh0000;
   endproperty
   a_empty_zero: assert property (p_empty_zero) else $error("empty query not zero"); // see RULE2

   property p_q_bound;
      cnt_r <= 4'(setc_pkg::ERRQ_DEPTH);
   endproperty
   a_q_bound: assert property (p_q_bound) else $error("queue count overrun"); // see RULE3

   property p_idle_trig;
      op == setc_pkg::OP_TRIG && !armed_r |=> $stable(lvl_active);
   endproperty
   a_idle_trig: assert property (p_idle_trig) else $error("unarmed trigger moved level"); // see RULE6

   property p_trig_copy;
      trig_fire |=> lvl_active == $past(pend_r);
   endproperty
   a_trig_copy: assert property (p_trig_copy) else $error("trigger did not copy"); // see RULE7

   property p_single;
      trig_fire && !cont_r |=> !trig_armed && !waiting_for_trigger_flag;
   endproperty
   a_single: assert property (p_single) else $error("single mode stayed armed"); // see RULE8

   property p_cont;
      (trig_fire || abort_evt) && cont_r && op != setc_pkg::OP_CONT_WR
      |=> trig_armed && waiting_for_trigger_flag;
   endproperty
   a_cont: assert property (p_cont) else $error("continuous did not rearm"); // see RULE9

   property p_abort_pend;
      abort_evt |=> lvl_pending == $past(imm_r);
   endproperty
   a_abort_pend: assert property (p_abort_pend) else $error("abort kept pending"); // see RULE11

   property p_mss;
      ##1 status_byte[setc_pkg::STB_MSS] == |(status_byte & $past(sre_r) & setc_pkg::SRE_MASK);
   endproperty
   a_mss: assert property (p_mss) else $error("summary bit wrong"); // see RULE18

   property p_no_srq;
      sre_r == 8'h00 |=> !srq;
   endproperty
   a_no_srq: assert property (p_no_srq) else $error("service request with zero mask"); // see RULE23

   property p_esr_read;
      esr_rd && esr_set == 8'h00 |=> esr_rd_data == $past(esr_r) && esr_r == 8'h00;
   endproperty
   a_esr_read: assert property (p_esr_read) else $error("event read not clearing"); // see RULE21

   property p_hold_owner;
      owner_r == setc_pkg::PORT_SER && tr_gp && idle_r != IDLE_LIM
      |=> owner_r == setc_pkg::PORT_SER;
   endproperty
   a_hold_owner: assert property (p_hold_owner) else $error("owner stolen"); // see RULE16

   c_trig: cover property (trig_fire ##1 trig_armed);
   c_ovf: cover property (push_ovf);
   c_release: cover property (owner_r != setc_pkg::PORT_NONE
                              ##1 owner_r == setc_pkg::PORT_NONE);
   c_srq: cover property (!srq ##1 srq);
endmodule : setc_top

// *** bench/setc_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// host controller on the far side of both command ports
// ----------------------------------------
module setc_host_model #(
   parameter int BIT_CYC = 2
) (
   input wire logic clk_sys,
   output logic ser_rx,
   output logic gpib_dav_n
);
   // both lines rest at their idle high level
   initial begin
      ser_rx = 1'b1;
      gpib_dav_n = 1'b1;
   end

   // one character: start low, 8 data bits lsb first, no parity, 1 stop high
   task automatic send_ser(input logic [7:0] ch);
      logic [9:0] frame;
      frame = {1'b1, ch, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys);
         ser_rx <= frame[i];
         repeat (BIT_CYC - 1) @(posedge clk_sys);
      end
   endtask : send_ser

   // one parallel strobe, data valid held low for three cycles
   task automatic send_par();
      @(posedge clk_sys);
      gpib_dav_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      gpib_dav_n <= 1'b1;
   endtask : send_par
endmodule : setc_host_model

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   // ----------------------------------------
   // design hookup
   // ----------------------------------------
   localparam logic signed [15:0] KNOWN [5] = '{-16'sh64, -16'sh66, -16'sh6c, -16'shde, -16'sh190};
   logic clk_sys, rst_n, ser_rx, gpib_dav_n, err_valid, obuf_pending;
   setc_pkg::setc_cmd_t cmd;
   logic signed [15:0] err_code, c, vr;
   logic signed [15:0] lst [0:6];
   logic err_resp_valid, srq, obuf_flush, waiting_for_trigger_flag, trig_armed, cont_mode;
   logic signed [15:0] err_resp_code;
   setc_pkg::setc_msg_t err_resp_msg;
   logic [7:0] esr_rd_data, status_byte;
   setc_pkg::setc_lvl_t lvl_active, lvl_pending;
   setc_pkg::setc_port_t active_port;
   logic [31:0] seed;
   logic [18:0] exp_e;
   logic [18:0] exp_q [$];
   int failures = 0;
   int samples_checked = 0;
   int flushes = 0;

   setc_top #(.FRAME_CYCLES(20), .IDLE_CYCLES(200)) dut_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .ser_rx(ser_rx), .gpib_dav_n(gpib_dav_n),
      .cmd(cmd), .err_valid(err_valid), .err_code(err_code), .obuf_pending(obuf_pending),
      .err_resp_valid(err_resp_valid), .err_resp_code(err_resp_code),
      .err_resp_msg(err_resp_msg), .esr_rd_data(esr_rd_data), .status_byte(status_byte),
      .srq(srq), .obuf_flush(obuf_flush), .waiting_for_trigger_flag(waiting_for_trigger_flag),
      .trig_armed(trig_armed), .cont_mode(cont_mode), .lvl_active(lvl_active),
      .lvl_pending(lvl_pending), .active_port(active_port)
   );
   setc_host_model #(.BIT_CYC(2)) host_u (
      .clk_sys(clk_sys), .ser_rx(ser_rx), .gpib_dav_n(gpib_dav_n)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // message id expected for an error number
   function automatic setc_pkg::setc_msg_t msg_of(input logic signed [15:0] k);
      case (k)
         16'sh0: return setc_pkg::MSG_NO_ERROR;
         -16'sh64: return setc_pkg::MSG_CMD;
         -16'sh66: return setc_pkg::MSG_SYNTAX;
         -16'sh6c: return setc_pkg::MSG_PARAM;
         -16'shde: return setc_pkg::MSG_RANGE;
         -16'sh15e: return setc_pkg::MSG_OVERFLOW;
         -16'sh190: return setc_pkg::MSG_QUERY;
         default: return setc_pkg::MSG_OTHER;
      endcase
   endfunction : msg_of

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // one-cycle command, results settled when the task returns
   task automatic send_cmd(input setc_pkg::setc_op_t op, input logic [15:0] d, input logic src);
      @(posedge clk_sys);
      cmd <= '{valid: 1'b1, src: src, op: op, data: d};
      @(posedge clk_sys);
      cmd <= '0;
      @(posedge clk_sys);
      #1;
   endtask : send_cmd

   task automatic push_err(input logic signed [15:0] k);
      @(posedge clk_sys);
      err_valid <= 1'b1;
      err_code <= k;
      @(posedge clk_sys);
      err_valid <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : push_err

   // error query with its expected answer noted first
   task automatic query(input logic signed [15:0] k, input logic src);
      exp_q.push_back({k, msg_of(k)});
      send_cmd(setc_pkg::OP_ERR_Q, 16'h0, src);
   endtask : query

   // ----------------------------------------
   // clock, watchdog, answer monitor
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      tally_and_finish();
   end

   // every query answer is matched against the oldest note
   always @(posedge clk_sys) begin
      if (obuf_flush === 1'b1) flushes++;
      if (err_resp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("err_resp_none", {31'h0, err_resp_valid}, 32'h0);
         end else begin
            exp_e = exp_q.pop_front();
            check("err_code", {16'h0, err_resp_code}, {16'h0, exp_e[18:3]});
            check("err_msg", {29'h0, err_resp_msg}, {29'h0, exp_e[2:0]});
         end
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      cmd = '0;
      err_valid = 1'b0;
      err_code = '0;
      obuf_pending = 1'b0;
      seed = 32'hebe8;
      rst_n = 1'b0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      check("pend_por", lvl_pending, 32'h0);
      check("wtg_por", {31'h0, waiting_for_trigger_flag}, 32'h0);
      // serial traffic claims the command stream, parallel commands dropped
      host_u.send_ser(8'h2a);
      repeat (4) @(posedge clk_sys);
      #1;
      check("port_ser", 32'(active_port), 32'(setc_pkg::PORT_SER));
      send_cmd(setc_pkg::OP_ERR_Q, 16'h0, 1'b1);
      query(16'sh0, 1'b0);
      // listed codes come back oldest first, event bits by group
      foreach (KNOWN[i]) push_err(KNOWN[i]);
      foreach (KNOWN[i]) query(KNOWN[i], 1'b0);
      send_cmd(setc_pkg::OP_ESR_Q, 16'h0, 1'b0);
      check("esr_grp", {24'h0, esr_rd_data}, 32'hb4);
      send_cmd(setc_pkg::OP_ESR_Q, 16'h0, 1'b0);
      check("esr_clr", {24'h0, esr_rd_data}, 32'h0);
      // nine random execution errors overflow the queue
      for (int i = 0; i < 9; i++) begin
         seed = lfsr_next(seed);
         c = -16'shc8 - 16'(seed % 32'h64);
         if (i < 7) lst[i] = c;
         push_err(c);
      end
      for (int i = 0; i < 7; i++) query(lst[i], 1'b0);
      query(-16'sh15e, 1'b0);
      query(16'sh0, 1'b0);
      send_cmd(setc_pkg::OP_ESR_Q, 16'h0, 1'b0);
      check("esr_ovf", {24'h0, esr_rd_data}, 32'h18);
      // status byte summary bits under the two masks
      @(posedge clk_sys);
      obuf_pending <= 1'b1;
      send_cmd(setc_pkg::OP_SRE_WR, 16'h0, 1'b0);
      check("stb_mav", {24'h0, status_byte}, 32'h10);
      check("srq_off", {31'h0, srq}, 32'h0);
      send_cmd(setc_pkg::OP_ESE_WR, 16'h20, 1'b0);
      push_err(-16'sh66);
      send_cmd(setc_pkg::OP_SRE_WR, 16'h30, 1'b0);
      check("stb_mss", {24'h0, status_byte}, 32'h70);
      check("srq_on", {31'h0, srq}, 32'h1);
      send_cmd(setc_pkg::OP_SRE_WR, 16'h1, 1'b0);
      check("stb_mask", {24'h0, status_byte}, 32'h30);
      @(posedge clk_sys);
      obuf_pending <= 1'b0;
      send_cmd(setc_pkg::OP_CLS, 16'h0, 1'b0);
      check("stb_cls", {24'h0, status_byte}, 32'h0);
      query(16'sh0, 1'b0);
      send_cmd(setc_pkg::OP_ESR_Q, 16'h0, 1'b0);
      check("esr_cls", {24'h0, esr_rd_data}, 32'h0);
      // single trigger: ignored unarmed, one action per arm
      send_cmd(setc_pkg::OP_CURR, 16'h1234, 1'b0);
      send_cmd(setc_pkg::OP_TRIG, 16'h0, 1'b0);
      check("act_unarm", lvl_active, 32'h12340000);
      send_cmd(setc_pkg::OP_INIT, 16'h0, 1'b0);
      check("wtg_arm", {31'h0, waiting_for_trigger_flag}, 32'h1);
      seed = lfsr_next(seed);
      vr = seed[15:0];
      send_cmd(setc_pkg::OP_CURR_TRIG, 16'h0a5a, 1'b0);
      send_cmd(setc_pkg::OP_VOLT_TRIG, vr, 1'b0);
      send_cmd(setc_pkg::OP_TRIG, 16'h0, 1'b0);
      check("act_trig", lvl_active, {16'h0a5a, vr});
      check("wtg_trig", {30'h0, waiting_for_trigger_flag, trig_armed}, 32'h0);
      send_cmd(setc_pkg::OP_CURR_TRIG, 16'h0777, 1'b0);
      send_cmd(setc_pkg::OP_TRIG, 16'h0, 1'b0);
      check("act_once", lvl_active, {16'h0a5a, vr});
      send_cmd(setc_pkg::OP_ABORT, 16'h0, 1'b0);
      check("pend_abort", lvl_pending, {16'h0a5a, vr});
      // continuous mode re-arms after trigger and abort
      send_cmd(setc_pkg::OP_CONT_WR, 16'h1, 1'b0);
      check("cont_on", {31'h0, cont_mode}, 32'h1);
      send_cmd(setc_pkg::OP_INIT, 16'h0, 1'b0);
      send_cmd(setc_pkg::OP_TRIG, 16'h0, 1'b0);
      check("wtg_cont", {31'h0, waiting_for_trigger_flag}, 32'h1);
      send_cmd(setc_pkg::OP_ABORT, 16'h0, 1'b0);
      check("wtg_cab", {31'h0, waiting_for_trigger_flag}, 32'h1);
      send_cmd(setc_pkg::OP_CONT_WR, 16'h0, 1'b0);
      // reset, recall and abort all cancel an armed trigger
      foreach (KNOWN[i]) begin
         if (i < 3) begin
            send_cmd(setc_pkg::OP_INIT, 16'h0, 1'b0);
            send_cmd(setc_pkg::OP_CURR_TRIG, 16'h0100 + 16'(i), 1'b0);
            send_cmd(i == 0 ? setc_pkg::OP_RST : i == 1 ? setc_pkg::OP_RCL
               : setc_pkg::OP_ABORT, 16'h0, 1'b0);
            check("pend_cxl", lvl_pending, {16'h0a5a, vr});
            check("wtg_cxl", {31'h0, waiting_for_trigger_flag}, 32'h0);
         end
      end
      // owner released only after the idle span
      host_u.send_par();
      #1;
      check("port_hold", 32'(active_port), 32'(setc_pkg::PORT_SER));
      repeat (230) @(posedge clk_sys);
      #1;
      check("port_free", 32'(active_port), 32'(setc_pkg::PORT_NONE));
      host_u.send_par();
      repeat (2) @(posedge clk_sys);
      #1;
      check("port_par", 32'(active_port), 32'(setc_pkg::PORT_GPIB));
      send_cmd(setc_pkg::OP_ERR_Q, 16'h0, 1'b0);
      query(16'sh0, 1'b1);
      repeat (3) @(posedge clk_sys);
      check("notes_left", exp_q.size(), 32'h0);
      check("flush_cnt", flushes, 32'h1);
      tally_and_finish();
   end
endmodule : testbench
